// [src/hcsr_regs.sv]
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module hcsr_regs (
    // clock and reset
    input  wire  logic              pclk,
    input  wire  logic              presetn,
    // apb slave
    input  wire  logic              psel,
    input  wire  logic              penable,
    input  wire  logic              pwrite,
    input  wire  logic [7:0]        paddr,
    input  wire  logic [31:0]       pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // serial backplane
    input  wire  hcsr_pkg::hcsr_link_s link_in,
    output logic                    serial_data_out,
    output logic                    serial_data_oe_n,
    // datapath side
    input  wire  hcsr_pkg::hcsr_ev_s ev,
    output logic                    tx_slot_en,
    output logic                    rx_slot_en,
    output logic                    addr_accept,
    output logic                    rx_overflow_hunt,
    output logic                    tx_send_abort,
    output logic                    soft_reset_active,
    // system outputs
    output logic                    irq_n,
    output logic                    watchdog_out_n
);
    // whole module state
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  rsa;       // bit 0 kept zero
        logic [7:0]  ctb;
        logic [6:0]  tc;        // ic, cchan_tx_enable, clock_rate_select, slot bits
        logic        srst;
        logic        zcnt;      // zero writes seen in reset
        logic [7:0]  flags;
        logic [7:0]  mask;
        logic [1:0]  fct;
        logic [7:0]  cstat;
        logic        irq_n;
        logic        wd_n;
        logic [10:0] wd_cnt;
        logic [4:0]  s1;        // first sync stage
        logic [4:0]  s2;        // second sync stage
        logic [4:0]  s3;        // edge history of s2
        logic [8:0]  hcnt;      // clock edges since frame start
        logic        sdo;
        logic        sdo_oe_n;
        logic        tx_en;
        logic        rx_en;
        logic        accept;
        logic        hunt;
        logic        send_abort;
        logic        tx_packet_end_out_prev;
        logic [4:0]  txl_prev;
        logic [4:0]  rxl_prev;
        logic [3:0]  done_cnt;
    } hcsr_st_s;

    hcsr_st_s   st_reg;     // registered state
    hcsr_st_s   st_next;    // next state
    logic [7:0] set_vec;    // flag set requests this cycle
    logic       wr_done;    // completing write
    logic       rd_done;    // completing read
    logic       setup;      // apb setup cycle
    logic [7:0] wbyte;      // written byte

    // slot window decode for a bit index within the frame
    function automatic logic slot_on(input logic [3:0] tcb, input logic [7:0] bi);
        logic [4:0] ch;
        logic [2:0] b;
        logic       r;
        ch = bi[7:3];
        b  = bi[2:0];
        r  = 1'b0;
        unique case (tcb[2:0])
            3'h0: r = (ch == 5'h00) && (b == 3'h0);
            3'h1: r = (ch == 5'h00) && (b < 3'h2);
            3'h2: r = (ch == 5'h00) && (b < (tcb[3] ? hcsr_pkg::CH_DATA_B
                                                     : hcsr_pkg::CH_DATA_A));
            3'h3: r = (ch == 5'h02);
            3'h4: r = (ch == 5'h03);
            3'h5: r = (ch == 5'h04);
            3'h6: r = (ch == 5'h02) || (ch == 5'h03);
            3'h7: r = (ch >= 5'h02) && (ch <= 5'h04);
        endcase
        return r;
    endfunction : slot_on

    // bus phase decode
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && st_reg.pready && pwrite;
    assign rd_done = psel && penable && st_reg.pready && !pwrite;
    assign wbyte   = pwdata[7:0];

    // next-state logic
    always_comb begin
        logic       sck_rise;
        logic       sck_fall;
        logic       fp_fall;
        logic       fp_low;
        logic       ic;
        logic       clock_rate_select;
        logic       bit_tick;
        logic [7:0] bi;
        logic [4:0] ch;
        logic       slot;
        logic [7:1] cmp_mask;
        st_next  = st_reg;
        set_vec  = 8'h00;
        // bit order in s*: sck, fp, sdi, txg, rxg
        sck_rise = st_reg.s2[4] && !st_reg.s3[4];
        sck_fall = !st_reg.s2[4] && st_reg.s3[4];
        fp_fall  = !st_reg.s2[3] && st_reg.s3[3];
        fp_low   = !st_reg.s2[3];
        ic       = st_reg.tc[hcsr_pkg::TRC_IC];
        clock_rate_select     = st_reg.tc[hcsr_pkg::TRC_CLOCK_RATE_SELECT];
        // two-stage pin synchroniser, s1 read only by s2
        st_next.s1 = link_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;

        // frame timing: frame pulse restarts the edge count
        if (sck_rise) begin
            st_next.hcnt = fp_low ? 9'h000 : st_reg.hcnt + 9'h001;
        end
        // bit index halves the count for a double-rate clock
        bi = clock_rate_select ? st_next.hcnt[7:0] : st_next.hcnt[8:1];
        ch = bi[7:3];
        // one bit boundary per bit period, or every clock rise in external timing
        bit_tick = sck_rise && (!ic || clock_rate_select || !st_next.hcnt[0]);
        slot = slot_on(st_reg.tc[3:0], bi);

        // serial output and section enables
        if (!ic) begin
            st_next.sdo      = ev.tx_bit;
            st_next.sdo_oe_n = st_reg.s2[1];
            st_next.tx_en    = !st_reg.s2[1];
            st_next.rx_en    = !st_reg.s2[0];
        end else if (slot) begin
            st_next.sdo      = ev.tx_bit;
            st_next.sdo_oe_n = 1'b0;
            st_next.tx_en    = 1'b1;
            st_next.rx_en    = 1'b1;
        end else if (ch == 5'h01 && st_reg.tc[hcsr_pkg::TRC_CCHAN_TX_ENABLE]) begin
            st_next.sdo      = st_reg.ctb[bi[2:0]];
            st_next.sdo_oe_n = 1'b0;
            st_next.tx_en    = 1'b0;
            st_next.rx_en    = 1'b0;
        end else begin
            // unselected time and disabled channel one float
            st_next.sdo      = 1'b1;
            st_next.sdo_oe_n = 1'b1;
            st_next.tx_en    = 1'b0;
            st_next.rx_en    = 1'b0;
        end
        // channel one received whatever the enable
        if (ic && sck_fall && ch == 5'h01) begin
            st_next.cstat[bi[2:0]] = st_reg.s2[2];
        end

        // address filter, bit zero never compared
        cmp_mask = st_reg.fct[hcsr_pkg::FCT_SIX] ? 7'h7e : 7'h7f;
        st_next.accept = 1'b0;
        if (ev.rx_addr_valid) begin
            st_next.accept = !st_reg.fct[hcsr_pkg::FCT_EN]
                || (((ev.rx_addr[7:1] ^ st_reg.rsa[7:1]) & cmp_mask) == 7'h00)
                || ((ev.rx_addr[7:1] & cmp_mask) == cmp_mask);
        end

        // flag sources
        set_vec[hcsr_pkg::FL_GA]    = ev.go_ahead;
        set_vec[hcsr_pkg::FL_PACKET_END_FLAG]  = ev.packet_end;
        set_vec[hcsr_pkg::FL_FA]    = ev.abort_seen;
        set_vec[hcsr_pkg::FL_TXLOW] = (st_reg.txl_prev == hcsr_pkg::TX_LOW_LVL + 5'h01)
                                      && (ev.tx_level == hcsr_pkg::TX_LOW_LVL);
        set_vec[hcsr_pkg::FL_URUN]  = (st_reg.txl_prev != 5'h00) && (ev.tx_level == 5'h00)
                                      && !ev.tx_last_tagged;
        set_vec[hcsr_pkg::FL_RXHI]  = (st_reg.rxl_prev != hcsr_pkg::RX_HI_LVL)
                                      && (ev.rx_level == hcsr_pkg::RX_HI_LVL);
        set_vec[hcsr_pkg::FL_OFLW]  = ev.rx_write && ev.rx_full;
        // done on packet-end fall with empty fifo, or after underrun delay
        set_vec[hcsr_pkg::FL_DONE]  = (st_reg.tx_packet_end_out_prev && !ev.tx_packet_end_out
                                       && ev.tx_level == 5'h00)
                                      || (bit_tick && st_reg.done_cnt == 4'h1);
        st_next.tx_packet_end_out_prev  = ev.tx_packet_end_out;
        st_next.txl_prev   = ev.tx_level;
        st_next.rxl_prev   = ev.rx_level;
        st_next.hunt       = set_vec[hcsr_pkg::FL_OFLW];
        st_next.send_abort = set_vec[hcsr_pkg::FL_URUN];
        // underrun delay counter in bit times
        if (set_vec[hcsr_pkg::FL_URUN]) begin
            st_next.done_cnt = hcsr_pkg::DONE_BITS;
        end else if (bit_tick && st_reg.done_cnt != 4'h0) begin
            st_next.done_cnt = st_reg.done_cnt - 4'h1;
        end

        // flag read clears only what was returned; new sets win
        if (rd_done && paddr == hcsr_pkg::OFS_IFL) begin
            st_next.flags = st_reg.flags & ~st_reg.prdata[7:0];
        end
        st_next.flags = st_next.flags | set_vec;

        // watchdog counts frame pulses in both timing modes
        if (fp_fall && st_reg.wd_n) begin
            st_next.wd_cnt = st_reg.wd_cnt + 11'h001;
            if (st_reg.wd_cnt == hcsr_pkg::WD_FRAMES - 11'h001) begin
                st_next.wd_n = 1'b0;
            end
        end

        // register writes
        if (wr_done) begin
            unique case (paddr)
                hcsr_pkg::OFS_RSA: st_next.rsa = {wbyte[7:1], 1'b0};
                hcsr_pkg::OFS_CTB: st_next.ctb = wbyte;
                hcsr_pkg::OFS_IMK: st_next.mask = wbyte;
                hcsr_pkg::OFS_FCT: st_next.fct = wbyte[1:0];
                hcsr_pkg::OFS_WDR: begin
                    // only the restart code has any effect
                    if (wbyte[4:0] == hcsr_pkg::WD_CODE) begin
                        st_next.wd_cnt = 11'h000;
                        st_next.wd_n   = 1'b1;
                    end
                end
                hcsr_pkg::OFS_TRC: begin
                    if (wbyte[hcsr_pkg::TRC_RST]) begin
                        st_next.srst = 1'b1;
                        st_next.zcnt = 1'b0;
                    end else if (st_reg.srst) begin
                        // second zero write releases the reset
                        st_next.zcnt = 1'b1;
                        st_next.srst = !st_reg.zcnt;
                        if (st_reg.zcnt) begin
                            st_next.zcnt = 1'b0;
                        end
                    end else begin
                        st_next.tc = wbyte[6:0];
                    end
                end
                default: ;
            endcase
        end

        // apb: no wait states, answer built in setup
        st_next.pready  = setup;
        st_next.pslverr = 1'b0;
        if (setup) begin
            st_next.prdata = 32'h0000_0000;
            unique case (paddr)
                hcsr_pkg::OFS_RSA: st_next.prdata[7:0] = {st_reg.rsa[7:1], 1'b0};
                hcsr_pkg::OFS_CTB: st_next.prdata[7:0] = st_reg.ctb;
                hcsr_pkg::OFS_TRC: st_next.prdata[7:0] = {st_reg.srst, st_reg.tc};
                hcsr_pkg::OFS_IFL: st_next.prdata[7:0] = st_reg.flags;
                hcsr_pkg::OFS_WDR: st_next.prdata[7:0] = hcsr_pkg::RST_BYTE;
                hcsr_pkg::OFS_IMK: st_next.prdata[7:0] = st_reg.mask;
                hcsr_pkg::OFS_FCT: st_next.prdata[1:0] = st_reg.fct;
                hcsr_pkg::OFS_CST: st_next.prdata[7:0] = st_reg.cstat;
                hcsr_pkg::OFS_GST: begin
                    st_next.prdata[hcsr_pkg::GST_IRQ]  = !st_reg.irq_n;
                    st_next.prdata[hcsr_pkg::GST_SRST] = st_reg.srst;
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end

        // interrupt output from enabled flags
        st_next.irq_n = !(|(st_reg.flags & st_reg.mask));

        // software reset holds registers, flags and outputs but not itself, the watchdog, the apb answer, sync stages or frame count
        if (st_next.srst) begin
            st_next.rsa        = hcsr_pkg::RST_BYTE;
            st_next.ctb        = hcsr_pkg::RST_BYTE;
            st_next.tc         = 7'h00;
            st_next.flags      = hcsr_pkg::RST_BYTE;
            st_next.mask       = hcsr_pkg::RST_BYTE;
            st_next.fct        = 2'h0;
            st_next.cstat      = hcsr_pkg::RST_BYTE;
            st_next.irq_n      = 1'b1;
            st_next.sdo        = 1'b1;
            st_next.sdo_oe_n   = 1'b1;
            st_next.tx_en      = 1'b0;
            st_next.rx_en      = 1'b0;
            st_next.accept     = 1'b0;
            st_next.hunt       = 1'b0;
            st_next.send_abort = 1'b0;
            st_next.done_cnt   = 4'h0;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.irq_n    <= 1'b1;
            st_reg.sdo      <= 1'b1;
            st_reg.sdo_oe_n <= 1'b1;
            st_reg.s1       <= 5'h1f;
            st_reg.s2       <= 5'h1f;
            st_reg.s3       <= 5'h1f;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign pready            = st_reg.pready;
    assign pslverr           = st_reg.pslverr;
    assign prdata            = st_reg.prdata;
    assign serial_data_out   = st_reg.sdo;
    assign serial_data_oe_n  = st_reg.sdo_oe_n;
    assign tx_slot_en        = st_reg.tx_en;
    assign rx_slot_en        = st_reg.rx_en;
    assign addr_accept       = st_reg.accept;
    assign rx_overflow_hunt  = st_reg.hunt;
    assign tx_send_abort     = st_reg.send_abort;
    assign soft_reset_active = st_reg.srst;
    assign irq_n             = st_reg.irq_n;
    assign watchdog_out_n    = st_reg.wd_n;

    // checks
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.srst ##1 !st_reg.srst |-> irq_n == !$past(|(st_reg.flags & st_reg.mask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq output disagrees with flags");

    property p_gst;
        @(posedge pclk) disable iff (!presetn)
        setup && paddr == hcsr_pkg::OFS_GST |=> prdata[hcsr_pkg::GST_IRQ] == $past(!irq_n);
    endproperty
    a_gst: assert property (p_gst) else $error("status irq bit wrong");

    property p_rsa0;
        @(posedge pclk) disable iff (!presetn)
        setup && paddr == hcsr_pkg::OFS_RSA |=> prdata[0] == 1'b0 && pready;
    endproperty
    a_rsa0: assert property (p_rsa0) else $error("address bit zero not zero");

    property p_clr;
        @(posedge pclk) disable iff (!presetn)
        rd_done && paddr == hcsr_pkg::OFS_IFL && set_vec == 8'h00
        |=> (st_reg.flags & $past(prdata[7:0])) == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("flag read did not clear");

    property p_wd_restart;
        @(posedge pclk) disable iff (!presetn)
        wr_done && paddr == hcsr_pkg::OFS_WDR && wbyte[4:0] == hcsr_pkg::WD_CODE
        |=> watchdog_out_n && st_reg.wd_cnt == 11'h000;
    endproperty
    a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");

    property p_wd_expire;
        @(posedge pclk) disable iff (!presetn)
        $fell(watchdog_out_n) |-> $past(st_reg.wd_cnt) == hcsr_pkg::WD_FRAMES - 11'h001;
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("watchdog fired early");

    property p_srst_exit;
        @(posedge pclk) disable iff (!presetn)
        $fell(soft_reset_active) |-> $past(wr_done) && $past(st_reg.zcnt)
                                     && !$past(wbyte[hcsr_pkg::TRC_RST]);
    endproperty
    a_srst_exit: assert property (p_srst_exit) else $error("reset left without two zero writes");

    property p_ext_gate;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.srst && !st_next.srst && !st_reg.tc[hcsr_pkg::TRC_IC]
        |=> serial_data_oe_n == $past(st_reg.s2[1]);
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("external gate not followed");

    property p_filter_off;
        @(posedge pclk) disable iff (!presetn)
        ev.rx_addr_valid && !st_reg.fct[hcsr_pkg::FCT_EN] && !st_reg.srst && !st_next.srst
        |=> addr_accept;
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("unfiltered address refused");

    c_flag_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_done && paddr == hcsr_pkg::OFS_IFL && prdata[7:0] != 8'h00);
    c_srst_exit: cover property (@(posedge pclk) disable iff (!presetn) $fell(soft_reset_active));
    c_wd_fire:   cover property (@(posedge pclk) disable iff (!presetn) $fell(watchdog_out_n));
    c_accept:    cover property (@(posedge pclk) disable iff (!presetn)
        addr_accept && st_reg.fct[hcsr_pkg::FCT_EN]);
endmodule : hcsr_regs
`default_nettype wire

// [src/hcsr_pkg.sv]
`default_nettype none
package hcsr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_RSA  = 8'h00;  // receive_station_address
    localparam logic [7:0] OFS_CTB  = 8'h04;  // cchan_transmit_byte
    localparam logic [7:0] OFS_TRC  = 8'h08;  // timing_and_reset_control
    localparam logic [7:0] OFS_IFL  = 8'h0c;  // interrupt_flags
    localparam logic [7:0] OFS_WDR  = 8'h10;  // watchdog_restart
    localparam logic [7:0] OFS_IMK  = 8'h14;  // interrupt_mask
    localparam logic [7:0] OFS_FCT  = 8'h18;  // filter control
    localparam logic [7:0] OFS_CST  = 8'h1c;  // channel-one status
    localparam logic [7:0] OFS_GST  = 8'h20;  // general status
    // timing control fields
    localparam int TRC_RST  = 7;
    localparam int TRC_IC   = 6;
    localparam int TRC_CCHAN_TX_ENABLE = 5;
    localparam int TRC_CLOCK_RATE_SELECT = 4;
    // filter control fields
    localparam int FCT_EN   = 1;
    localparam int FCT_SIX  = 0;
    // general status fields
    localparam int GST_IRQ  = 3;
    localparam int GST_SRST = 0;
    // interrupt flag positions
    localparam int FL_GA    = 7;
    localparam int FL_PACKET_END_FLAG  = 6;
    localparam int FL_DONE  = 5;
    localparam int FL_FA    = 4;
    localparam int FL_TXLOW = 3;
    localparam int FL_URUN  = 2;
    localparam int FL_RXHI  = 1;
    localparam int FL_OFLW  = 0;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // watchdog restart code and span in frame pulses
    localparam logic [4:0]  WD_CODE   = 5'h0a;
    localparam logic [10:0] WD_FRAMES = 11'h400;
    // fifo thresholds and underrun delay in bit times
    localparam logic [4:0] TX_LOW_LVL = 5'h04;
    localparam logic [4:0] RX_HI_LVL  = 5'h0f;
    localparam logic [3:0] DONE_BITS  = 4'h8;
    localparam logic [2:0] CH_DATA_A  = 3'h6;
    localparam logic [2:0] CH_DATA_B  = 3'h7;

    // link pins, all foreign to pclk
    typedef struct packed {
        logic serial_clock_in;
        logic frame_pulse_in;   // active low
        logic serial_data_in;
        logic tx_gate_n;
        logic rx_gate_n;
    } hcsr_link_s;

    // events and levels from the protocol datapath, pclk domain
    typedef struct packed {
        logic       go_ahead;
        logic       packet_end;
        logic       abort_seen;
        logic       tx_packet_end_out;
        logic       tx_last_tagged;
        logic       rx_write;
        logic       rx_full;
        logic [4:0] tx_level;
        logic [4:0] rx_level;
        logic       tx_bit;
        logic       rx_addr_valid;
        logic [7:0] rx_addr;
    } hcsr_ev_s;
endpackage : hcsr_pkg
`default_nettype wire

// [testbench/hcsr_link_model.sv]
`default_nettype none
module hcsr_link_model (
    // serial backplane pins
    output var hcsr_pkg::hcsr_link_s link
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cnt; // bit position in frame
    // bit-rate clock, 256 bits a frame
    initial begin
        link = '0;
        link.tx_gate_n = 1'b1; // gates idle
        link.rx_gate_n = 1'b1;
        bit_cnt = 0;
        forever begin
            #100 link.serial_clock_in = 1'b1;
            #100 link.serial_clock_in = 1'b0;
            bit_cnt = (bit_cnt + 1) % 256;
            // frame pulse low ahead of bit 0
            link.frame_pulse_in = (bit_cnt == 255) ? 1'b0 : 1'b1;
            link.serial_data_in = bit_cnt[0]; // toggles each bit
        end
    end
endmodule : hcsr_link_model
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic serial_data_out, serial_data_oe_n, tx_slot_en, rx_slot_en;
    logic addr_accept, rx_overflow_hunt, tx_send_abort, soft_reset_active;
    logic irq_n, watchdog_out_n, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    hcsr_pkg::hcsr_link_s link_in;
    hcsr_pkg::hcsr_ev_s ev;
    int n_fail, compares, n;
    // device and far side
    hcsr_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .link_in, .serial_data_out, .serial_data_oe_n, .ev, .tx_slot_en,
        .rx_slot_en, .addr_accept, .rx_overflow_hunt, .tx_send_abort, .soft_reset_active,
        .irq_n, .watchdog_out_n);
    hcsr_link_model link_model (.link(link_in));
    // 26 ns clock, the 12.5 ns half period rounds to 13 ns at 1 ns precision
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // verdict
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // one apb transfer, read data into rd
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            n_fail++;
            finish_test();
        end
    endtask : apb
    // one received address, accept checked when it stands
    task automatic addr_ev(input logic [7:0] a, input logic exp);
        @(posedge pclk) {ev.rx_addr_valid, ev.rx_addr} <= {1'b1, a};
        @(posedge pclk) ev.rx_addr_valid <= 1'b0;
        @(posedge pclk);
        chk("accept", addr_accept, exp);
    endtask : addr_ev
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ev, n_fail, compares} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, hcsr_pkg::OFS_RSA, 32'hff);
        apb(1'b0, hcsr_pkg::OFS_RSA, 0);
        chk("rsa", rd, 32'hfe);
        apb(1'b1, 8'h40, 32'h1);
        chk("unmapped", err, 1'b1);
        chk("wd rst", watchdog_out_n, 1'b0);
        apb(1'b1, hcsr_pkg::OFS_TRC, 32'h80);
        apb(1'b0, hcsr_pkg::OFS_RSA, 0);
        chk("rsa srst", rd, 32'h0);
        apb(1'b1, hcsr_pkg::OFS_TRC, 32'h0);
        chk("srst one", soft_reset_active, 1'b1);
        apb(1'b1, hcsr_pkg::OFS_TRC, 32'h0);
        @(posedge pclk);
        chk("srst two", soft_reset_active, 1'b0);
        apb(1'b1, hcsr_pkg::OFS_IMK, 32'h80);
        @(posedge pclk) {ev.go_ahead, ev.abort_seen} <= 2'b11;
        @(posedge pclk) {ev.go_ahead, ev.abort_seen} <= 2'b00;
        repeat (3) @(posedge pclk);
        chk("irq", irq_n, 1'b0);
        apb(1'b0, hcsr_pkg::OFS_GST, 0);
        chk("gst", rd, 32'h08);
        apb(1'b0, hcsr_pkg::OFS_IFL, 0);
        chk("flags", rd, 32'h90);
        apb(1'b0, hcsr_pkg::OFS_IFL, 0);
        chk("flags clr", rd, 32'h0);
        @(posedge pclk) ev.abort_seen <= 1'b1;
        @(posedge pclk) ev.abort_seen <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("masked", irq_n, 1'b1);
        apb(1'b0, hcsr_pkg::OFS_IFL, 0);
        chk("fa", rd, 32'h10);
        apb(1'b1, hcsr_pkg::OFS_TRC, 32'h53);
        for (n = 0; n < 3000 && serial_data_oe_n !== 1'b0; n++) @(posedge pclk);
        if (n >= 3000) n_fail++;
        chk("slot", tx_slot_en, 1'b1);
        chk("rx slot", rx_slot_en, 1'b1);
        chk("sdo", serial_data_out, 1'b0);
        apb(1'b1, hcsr_pkg::OFS_WDR, 32'h0a);
        @(posedge pclk);
        chk("wd", watchdog_out_n, 1'b1);
        apb(1'b1, hcsr_pkg::OFS_FCT, 32'h2);
        apb(1'b1, hcsr_pkg::OFS_RSA, 32'h42);
        addr_ev(8'h43, 1'b1);
        addr_ev(8'h44, 1'b0);
        addr_ev(8'hff, 1'b1);
        @(posedge pclk) {ev.rx_write, ev.rx_full} <= 2'b11;
        @(posedge pclk) {ev.rx_write, ev.rx_full} <= 2'b00;
        @(posedge pclk);
        chk("hunt", rx_overflow_hunt, 1'b1);
        @(posedge pclk) ev.tx_level <= 5'h01;
        @(posedge pclk) ev.tx_level <= 5'h00;
        repeat (2) @(posedge pclk);
        chk("abort", tx_send_abort, 1'b1);
        repeat (100) @(posedge pclk);
        apb(1'b0, hcsr_pkg::OFS_IFL, 0);
        chk("urun done", rd, 32'h25);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
